// ### shared/pdc_pkg.sv
package pdc_pkg;

    // Register map, one byte per address.
    localparam int PDC_NUM_REGS = 9;
    localparam int PDC_IDX_W = 4;
    localparam logic [7:0] PDC_ADDR_PUMP = 8'h0B;
    localparam logic [7:0] PDC_ADDR_SS_REF = 8'h0C;
    localparam logic [7:0] PDC_ADDR_SS_FB_HIGH = 8'h0D;
    localparam logic [7:0] PDC_ADDR_SS_FB_LOW = 8'h0E;
    localparam logic [7:0] PDC_ADDR_OUT_DIV = 8'h0F;
    localparam logic [7:0] PDC_ADDR_INT_HIGH = 8'h10;
    localparam logic [7:0] PDC_ADDR_INT_LOW = 8'h11;
    localparam logic [7:0] PDC_ADDR_FRAC_HIGH = 8'h12;
    localparam logic [7:0] PDC_ADDR_FRAC_LOW = 8'h13;
    localparam logic [7:0] PDC_ADDR_FIRST = PDC_ADDR_PUMP;
    localparam logic [7:0] PDC_ADDR_LAST = PDC_ADDR_FRAC_LOW;

    // Index of each register inside the bank.
    localparam int PDC_IDX_PUMP = 0;
    localparam int PDC_IDX_SS_REF = 1;
    localparam int PDC_IDX_SS_FB_HIGH = 2;
    localparam int PDC_IDX_SS_FB_LOW = 3;
    localparam int PDC_IDX_OUT_DIV = 4;
    localparam int PDC_IDX_INT_HIGH = 5;
    localparam int PDC_IDX_INT_LOW = 6;
    localparam int PDC_IDX_FRAC_HIGH = 7;
    localparam int PDC_IDX_FRAC_LOW = 8;

    // Reset values.
    localparam logic [7:0] PDC_RST_PUMP = 8'h06;
    localparam logic [7:0] PDC_RST_ZERO = 8'h00;
    localparam logic [7:0] PDC_RST_OUT_DIV = 8'h33;
    localparam logic [7:0] PDC_RST_INT_LOW = 8'h3C;
    localparam logic [10:0] PDC_RST_INT_DIV = 11'h03C;
    localparam logic [3:0] PDC_RST_OUT_DIVISOR = 4'h3;

    // Writable bits; clear bits are reserved and read as zero.
    localparam logic [7:0] PDC_MASK_FULL = 8'hFF;
    localparam logic [7:0] PDC_MASK_INT_HIGH = 8'h07;
    localparam logic [7:0] PDC_MASK_RESERVED = 8'hF8;

    localparam logic [PDC_NUM_REGS-1:0][7:0] PDC_RESET_TABLE = {
        PDC_RST_ZERO, PDC_RST_ZERO, PDC_RST_INT_LOW, PDC_RST_ZERO,
        PDC_RST_OUT_DIV, PDC_RST_ZERO, PDC_RST_ZERO, PDC_RST_ZERO,
        PDC_RST_PUMP};
    localparam logic [PDC_NUM_REGS-1:0][7:0] PDC_MASK_TABLE = {
        PDC_MASK_FULL, PDC_MASK_FULL, PDC_MASK_FULL, PDC_MASK_INT_HIGH,
        PDC_MASK_FULL, PDC_MASK_FULL, PDC_MASK_FULL, PDC_MASK_FULL,
        PDC_MASK_FULL};

    // Field positions.
    localparam int PDC_BIT_MUL32 = 7;
    localparam int PDC_BIT_MUL16 = 6;
    localparam int PDC_BIT_MUL8 = 5;
    localparam int PDC_BIT_MUL4 = 4;
    localparam int PDC_BIT_MUL2 = 3;
    localparam int PDC_BIT_MUL1 = 2;
    localparam int PDC_BIT_DIV24 = 1;
    localparam int PDC_BIT_DIV3 = 0;
    localparam int PDC_BIT_DIV23 = 7;
    localparam int PDC_REF_DIV_LSB = 0;
    localparam int PDC_REF_DIV_W = 7;
    localparam int PDC_OUT_DIVISOR_ONE_LSB = 4;
    localparam int PDC_OUT_DIVISOR_TWO_LSB = 0;
    localparam int PDC_OUTDIV_W = 4;
    localparam int PDC_INT_HIGH_LSB = 0;
    localparam int PDC_INT_HIGH_W = 3;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdc_req_s;

    typedef struct packed {
        logic rdValid;
        logic [7:0] rdData;
    } pdc_rsp_s;

    typedef struct packed {
        logic synth1PumpMul32;
        logic synth1PumpMul16;
        logic synth1PumpMul8;
        logic synth1PumpMul4;
        logic synth1PumpMul2;
        logic synth1PumpMul1;
        logic synth1PumpDiv24;
        logic synth1PumpDiv3;
        logic synth1SpreadRefDiv23Sel;
        logic [6:0] synth1SpreadRefDivisor;
        logic [15:0] synth1SpreadFbDivisor;
        logic [3:0] outDivisorOne;
        logic [3:0] outDivisorTwo;
        logic [2:0] synth2IntFbUpper;
        logic [7:0] synth2IntFbLower;
        logic [15:0] synth2FracFbDivisor;
    } pdc_fields_s;

    typedef struct packed {
        logic [7:0] value;
    } pdc_byte_state_s;

    typedef struct packed {
        logic rdValid;
        logic [7:0] rdData;
    } pdc_bank_state_s;

    function automatic logic pdc_reg_hit(input logic [7:0] addr);
        return (addr >= PDC_ADDR_FIRST) && (addr <= PDC_ADDR_LAST);
    endfunction : pdc_reg_hit

    function automatic logic [PDC_IDX_W-1:0] pdc_reg_index(
        input logic [7:0] addr);
        logic [7:0] offset;
        offset = addr - PDC_ADDR_FIRST;
        return offset[PDC_IDX_W-1:0];
    endfunction : pdc_reg_index

endpackage : pdc_pkg

// ### hdl/pdc_byte_reg.sv
module pdc_byte_reg
    import pdc_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic writeEn,
    input wire logic [7:0] writeData,
    output logic [7:0] value
);

    pdc_byte_state_s state;
    pdc_byte_state_s next_state;

    // Bits outside the mask keep their reset value whatever is written.
    always_comb begin
        next_state = state;
        if (writeEn) begin
            next_state.value = (writeData & WRITE_MASK)
                | (state.value & ~WRITE_MASK);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state.value <= RESET_VALUE;
        end else begin
            state <= next_state;
        end
    end

    assign value = state.value;

endmodule : pdc_byte_reg

// ### hdl/pdc_config_regs.sv
module pdc_config_regs
    import pdc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire pdc_req_s req,
    output pdc_rsp_s rsp,
    output pdc_fields_s fields
);

    logic [PDC_NUM_REGS-1:0][7:0] regs;
    logic [PDC_NUM_REGS-1:0] wrSel;
    logic wrHit;
    logic rdHit;
    logic [PDC_IDX_W-1:0] wrIndex;
    logic [PDC_IDX_W-1:0] rdIndex;
    pdc_bank_state_s state;
    pdc_bank_state_s next_state;

    assign wrHit = req.wrEn && pdc_reg_hit(req.addr);
    assign rdHit = pdc_reg_hit(req.addr);
    assign wrIndex = pdc_reg_index(req.addr);
    assign rdIndex = pdc_reg_index(req.addr);

    // One byte register per address; reset and writable bits per entry.
    for (genvar i = 0; i < PDC_NUM_REGS; i++) begin : g_reg
        assign wrSel[i] = wrHit && (wrIndex == PDC_IDX_W'(i));
        pdc_byte_reg #(
            .RESET_VALUE(PDC_RESET_TABLE[i]),
            .WRITE_MASK(PDC_MASK_TABLE[i])
        ) u_reg (
            .clock(clock),
            .srst(srst),
            .writeEn(wrSel[i]),
            .writeData(req.wdata),
            .value(regs[i])
        );
    end

    // Reads answer one cycle later; unmapped addresses read as zero.
    always_comb begin
        next_state = state;
        next_state.rdValid = req.rdEn;
        if (req.rdEn) begin
            if (rdHit) begin
                next_state.rdData = regs[rdIndex];
            end else begin
                next_state.rdData = PDC_RST_ZERO;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state.rdValid <= 1'b0;
            state.rdData <= PDC_RST_ZERO;
        end else begin
            state <= next_state;
        end
    end

    assign rsp.rdValid = state.rdValid;
    assign rsp.rdData = state.rdData;

    // Pump weighting bits.
    assign fields.synth1PumpMul32 = regs[PDC_IDX_PUMP][PDC_BIT_MUL32];
    assign fields.synth1PumpMul16 = regs[PDC_IDX_PUMP][PDC_BIT_MUL16];
    assign fields.synth1PumpMul8 = regs[PDC_IDX_PUMP][PDC_BIT_MUL8];
    assign fields.synth1PumpMul4 = regs[PDC_IDX_PUMP][PDC_BIT_MUL4];
    assign fields.synth1PumpMul2 = regs[PDC_IDX_PUMP][PDC_BIT_MUL2];
    assign fields.synth1PumpMul1 = regs[PDC_IDX_PUMP][PDC_BIT_MUL1];
    assign fields.synth1PumpDiv24 = regs[PDC_IDX_PUMP][PDC_BIT_DIV24];
    assign fields.synth1PumpDiv3 = regs[PDC_IDX_PUMP][PDC_BIT_DIV3];

    // Spread reference divider.
    assign fields.synth1SpreadRefDiv23Sel =
        regs[PDC_IDX_SS_REF][PDC_BIT_DIV23];
    assign fields.synth1SpreadRefDivisor =
        regs[PDC_IDX_SS_REF][PDC_REF_DIV_LSB +: PDC_REF_DIV_W];

    // Spread feedback divider, high byte first.
    assign fields.synth1SpreadFbDivisor =
        {regs[PDC_IDX_SS_FB_HIGH], regs[PDC_IDX_SS_FB_LOW]};

    // Output divider pair.
    assign fields.outDivisorOne =
        regs[PDC_IDX_OUT_DIV][PDC_OUT_DIVISOR_ONE_LSB +: PDC_OUTDIV_W];
    assign fields.outDivisorTwo =
        regs[PDC_IDX_OUT_DIV][PDC_OUT_DIVISOR_TWO_LSB +: PDC_OUTDIV_W];

    // Second synthesizer integer and fractional dividers.
    assign fields.synth2IntFbUpper =
        regs[PDC_IDX_INT_HIGH][PDC_INT_HIGH_LSB +: PDC_INT_HIGH_W];
    assign fields.synth2IntFbLower = regs[PDC_IDX_INT_LOW];
    assign fields.synth2FracFbDivisor =
        {regs[PDC_IDX_FRAC_HIGH], regs[PDC_IDX_FRAC_LOW]};

    a_pump_reset:
    assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> regs[PDC_IDX_PUMP] == PDC_RST_PUMP
            && fields.synth1PumpMul1 && fields.synth1PumpDiv24
            && !fields.synth1PumpMul32)
    else $error("Pump weighting reset value is wrong.");

    a_pump_write:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_PUMP
            |=> {fields.synth1PumpMul32, fields.synth1PumpMul16,
                fields.synth1PumpMul8, fields.synth1PumpMul4,
                fields.synth1PumpMul2, fields.synth1PumpMul1,
                fields.synth1PumpDiv24, fields.synth1PumpDiv3}
                == $past(req.wdata))
    else $error("Pump weighting write not stored.");

    a_ref_write:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_SS_REF
            |=> fields.synth1SpreadRefDiv23Sel == $past(req.wdata[7])
            && fields.synth1SpreadRefDivisor == $past(req.wdata[6:0]))
    else $error("Spread reference write not stored.");

    a_ref_reset:
    assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> !fields.synth1SpreadRefDiv23Sel
            && fields.synth1SpreadRefDivisor == 7'h00)
    else $error("Spread reference byte not zero after reset.");

    a_fb_bytes:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_SS_FB_HIGH
            && !$past(req.wrEn)
            |=> fields.synth1SpreadFbDivisor[15:8] == $past(req.wdata)
            ##1 (!$past(req.wrEn) || $past(req.addr) != PDC_ADDR_SS_FB_HIGH)
                || fields.synth1SpreadFbDivisor[15:8] == $past(req.wdata))
    else $error("Spread feedback high byte not stored.");

    a_fb_low:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_SS_FB_LOW
            |=> fields.synth1SpreadFbDivisor[7:0] == $past(req.wdata))
    else $error("Spread feedback low byte not stored.");

    a_div_one_reset:
    assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> fields.outDivisorOne == PDC_RST_OUT_DIVISOR)
    else $error("Output divisor one reset value is wrong.");

    a_div_one_write:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_OUT_DIV
            |=> fields.outDivisorOne == $past(req.wdata[7:4]))
    else $error("Output divisor one not taken from upper nibble.");

    a_div_two_write:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_OUT_DIV
            |=> fields.outDivisorTwo == $past(req.wdata[3:0])
            && $stable(fields.synth2IntFbLower))
    else $error("Output divisor two not taken from lower nibble.");

    a_div_two_reset:
    assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> fields.outDivisorTwo == PDC_RST_OUT_DIVISOR)
    else $error("Output divisor two reset value is wrong.");

    a_int_reset:
    assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> {fields.synth2IntFbUpper, fields.synth2IntFbLower}
            == PDC_RST_INT_DIV)
    else $error("Integer divisor reset value is wrong.");

    a_int_upper:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_INT_HIGH
            |=> fields.synth2IntFbUpper == $past(req.wdata[2:0]))
    else $error("Integer divisor upper bits not stored.");

    a_frac_high:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_FRAC_HIGH
            |=> fields.synth2FracFbDivisor[15:8] == $past(req.wdata)
            && $stable(fields.synth2FracFbDivisor[7:0]))
    else $error("Fractional divisor high byte not stored.");

    a_frac_reset:
    assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> fields.synth2FracFbDivisor == 16'h0000)
    else $error("Fractional divisor not zero after reset.");

    a_reserved_read:
    assert property (@(posedge clock) disable iff (srst)
        req.rdEn && req.addr == PDC_ADDR_INT_HIGH
            |=> rsp.rdValid && (rsp.rdData & PDC_MASK_RESERVED) == 8'h00)
    else $error("Reserved bits of the integer high byte read nonzero.");

    a_read_answer:
    assert property (@(posedge clock) disable iff (srst)
        req.rdEn && !pdc_reg_hit(req.addr)
            |=> rsp.rdValid && rsp.rdData == 8'h00)
    else $error("Unmapped read did not answer zero.");

    a_fb_reset:
    assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> fields.synth1SpreadFbDivisor == 16'h0000)
    else $error("Spread feedback divisor not zero after reset.");

    a_int_lower:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_INT_LOW
            |=> fields.synth2IntFbLower == $past(req.wdata)
            && $stable(fields.synth2IntFbUpper))
    else $error("Integer divisor lower byte not stored.");

    a_frac_low:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_FRAC_LOW
            |=> fields.synth2FracFbDivisor[7:0] == $past(req.wdata)
            && $stable(fields.synth2FracFbDivisor[15:8]))
    else $error("Fractional divisor low byte not stored.");

    a_reserved_write:
    assert property (@(posedge clock) disable iff (srst)
        req.wrEn && req.addr == PDC_ADDR_INT_HIGH
            |=> (regs[PDC_IDX_INT_HIGH] & PDC_MASK_RESERVED)
            == PDC_RST_ZERO)
    else $error("Reserved bits of the integer high byte took a write.");

    a_read_valid:
    assert property (@(posedge clock) disable iff (srst)
        !$past(srst) |-> rsp.rdValid == $past(req.rdEn))
    else $error("Read answer strobe not one cycle after the request.");

endmodule : pdc_config_regs

// ### bench/pdc_config_regs_bench.sv
module pdc_config_regs_bench
    import pdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock;
    logic srst;
    pdc_req_s req;
    pdc_rsp_s rsp;
    pdc_fields_s fields;
    logic [7:0] model [PDC_NUM_REGS];
    int errors;
    int cmp_count;
    int seed;
    int i;
    int b;
    int n;
    int op;
    logic [7:0] ra;
    logic [7:0] rv;

    pdc_config_regs i_dut (
        .clock(clock),
        .srst(srst),
        .req(req),
        .rsp(rsp),
        .fields(fields)
    );

    // Power-up contents of each byte, counted from 0Bh.
    function automatic logic [7:0] rst_val(input int k);
        case (k)
            0: return 8'h06;
            4: return 8'h33;
            6: return 8'h3C;
            default: return 8'h00;
        endcase
    endfunction : rst_val

    function automatic logic is_mapped(input logic [7:0] a);
        return (a >= 8'h0B) && (a <= 8'h13);
    endfunction : is_mapped

    // Settings as the bank should present them, built from the byte model.
    function automatic pdc_fields_s fexp();
        return {model[0], model[1], model[2], model[3], model[4],
            model[5][2:0], model[6], model[7], model[8]};
    endfunction : fexp

    task automatic model_reset();
        for (int k = 0; k < PDC_NUM_REGS; k++) begin
            model[k] = rst_val(k);
        end
    endtask : model_reset

    task automatic chk(input logic [127:0] got, input logic [127:0] want,
        input string what);
        cmp_count++;
        if (got !== want) begin
            errors++;
            $display("BAD %0t %s got %0h want %0h", $time, what, got, want);
        end
    endtask : chk

    task automatic model_wr(input logic [7:0] a, input logic [7:0] d);
        if (is_mapped(a)) begin
            model[a - 8'h0B] = d & ((a == 8'h10) ? 8'h07 : 8'hFF);
        end
    endtask : model_wr

    // Write strobe stays up so that calls in a row give back-to-back writes.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req.wrEn = 1'b1;
        req.rdEn = 1'b0;
        req.addr = a;
        req.wdata = d;
        model_wr(a, d);
    endtask : wr

    task automatic idle();
        @(negedge clock);
        req = '0;
    endtask : idle

    // Read, optionally with a write to the same address in the same cycle.
    task automatic rd(input logic [7:0] a, input logic both,
        input logic [7:0] d);
        logic [7:0] want;
        @(negedge clock);
        chk(rsp.rdValid, 1'b0, "valid before read");
        want = is_mapped(a) ? model[a - 8'h0B] : 8'h00;
        req.rdEn = 1'b1;
        req.wrEn = both;
        req.addr = a;
        req.wdata = d;
        if (both) begin
            model_wr(a, d);
        end
        @(negedge clock);
        chk(rsp.rdValid, 1'b1, "valid after read");
        chk(rsp.rdData, want, "read data");
        chk(fields, fexp(), "fields");
        req = '0;
    endtask : rd

    task automatic test_done();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        #(50 * 5000);
        errors++;
        test_done();
    end

    initial begin
        seed = 8;
        errors = 0;
        cmp_count = 0;
        req = '0;
        srst = 1'b1;
        model_reset();
        repeat (12) @(posedge clock);
        @(negedge clock);
        chk(fields, fexp(), "fields in reset");
        srst = 1'b0;
        // Power-up values of every byte.
        for (i = 8'h0B; i <= 8'h13; i++) begin
            rd(i[7:0], 1'b0, 8'h00);
        end
        // One bit at a time through every byte, reserved bits included.
        for (i = 8'h0B; i <= 8'h13; i++) begin
            for (b = 0; b < 8; b++) begin
                wr(i[7:0], 8'h01 << b);
                rd(i[7:0], 1'b0, 8'h00);
            end
            wr(i[7:0], 8'hFF);
            idle();
            rd(i[7:0], 1'b0, 8'h00);
        end
        // Random mix of writes, reads and read-with-write, mapped or not.
        for (n = 0; n < 400; n++) begin
            op = {$random(seed)} % 3;
            ra = 8'($random(seed));
            rv = 8'($random(seed));
            if (n % 4 != 0) begin
                ra = ra & 8'h1F;
            end
            if (op == 0) begin
                wr(ra, rv);
                if (n % 5 == 0) begin
                    idle();
                end
            end else begin
                if (req.wrEn === 1'b1) begin
                    idle();
                end
                rd(ra, op == 2, rv);
            end
        end
        idle();
        // Reset in mid-run with a write on the bus; the write is lost.
        @(negedge clock);
        srst = 1'b1;
        req.wrEn = 1'b1;
        req.addr = 8'h0F;
        req.wdata = 8'h5A;
        model_reset();
        @(negedge clock);
        req = '0;
        chk(fields, fexp(), "fields after reset");
        chk(rsp, '0, "response in reset");
        srst = 1'b0;
        for (i = 8'h0B; i <= 8'h13; i++) begin
            rd(i[7:0], 1'b0, 8'h00);
        end
        test_done();
    end

endmodule : pdc_config_regs_bench
